// [inc/psq_pkg.sv]
// Constants, register map and state codes of the power resource sequencer.
// Assumes one 100 MHz system clock and a register port with one-cycle strobes.
package psq_pkg;

    // ==========================================================
    // Sizes and clocking.
    localparam int DATA_W      = 32;
    localparam int ADDR_W      = 8;
    localparam int RES_N       = 8;
    localparam int TIMER_W     = 16;
    localparam int CLK_REQ_N   = 4;
    localparam int SYS_CLK_HZ  = 100_000_000;
    localparam int SLEEP_CLK_MHZ_X1000 = 32768;
    localparam int SLEEP_DIV   = SYS_CLK_HZ / SLEEP_CLK_MHZ_X1000;
    localparam int HOST_SETTLE_US = 100;

    // ==========================================================
    // Register offsets.
    localparam logic [ADDR_W-1:0] OFS_CTRL      = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_MIN_RES   = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_RES_ON    = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_RES_PEND  = 8'h0c;
    localparam logic [ADDR_W-1:0] OFS_REQ_CNT   = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_REQ_MASK  = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_REQUIRED  = 8'h18;
    localparam logic [ADDR_W-1:0] OFS_REG_STAT  = 8'h1c;
    localparam logic [ADDR_W-1:0] OFS_DLY_SEL   = 8'h20;
    localparam logic [ADDR_W-1:0] OFS_ON_DLY    = 8'h24;
    localparam logic [ADDR_W-1:0] OFS_OFF_DLY   = 8'h28;

    // ==========================================================
    // Field positions.
    localparam int CTRL_PWM_BIT    = 0;
    localparam int CTRL_LPBURST_BIT = 1;
    localparam int CTRL_LNLIN_BIT  = 2;
    localparam int STAT_SW_ON_BIT  = 0;
    localparam int STAT_SW_PWM_BIT = 1;
    localparam int STAT_LIN_ON_BIT = 2;
    localparam int STAT_LPB_BIT    = 3;

    // ==========================================================
    // Reset values and default tables.
    localparam logic [2:0]         CTRL_RST      = 3'h0;
    localparam logic [RES_N-1:0]   MIN_RES_RST   = 8'h01;
    localparam logic [TIMER_W-1:0] DELAY_RST     = 16'h0002;
    localparam logic [RES_N*RES_N-1:0] DEP_DEFAULT = 64'h4020_1008_0402_0100;
    localparam logic [CLK_REQ_N*RES_N-1:0] CLK_MAP_DEFAULT = 32'h8040_2001;

    // ==========================================================
    // Resource states.
    typedef enum logic [3:0] {
        RES_DISABLED  = 4'b0001,
        RES_TURN_ON   = 4'b0010,
        RES_ENABLED   = 4'b0100,
        RES_TURN_OFF  = 4'b1000
    } psq_res_e;

endpackage

// [logic/psq_sequencer.sv]
// Power resource sequencer with core switching regulator mode selection.
// Assumes host pins are asynchronous and the register port is synchronous to clk_sys.
`timescale 1ns/100ps
`default_nettype none

module psq_sequencer #(
    parameter int                         N        = psq_pkg::RES_N,
    parameter int                         TW       = psq_pkg::TIMER_W,
    parameter int                         CN       = psq_pkg::CLK_REQ_N,
    parameter int                         DIV      = psq_pkg::SLEEP_DIV,
    parameter logic [N*N-1:0]             DEP_TABLE = psq_pkg::DEP_DEFAULT,
    parameter logic [CN*N-1:0]            CLK_MAP  = psq_pkg::CLK_MAP_DEFAULT
) (
    // Clock and reset.
    input  wire logic                          clk_sys,
    input  wire logic                          reset,
    // Register port.
    input  wire logic [psq_pkg::ADDR_W-1:0]    regAddr,
    input  wire logic [psq_pkg::DATA_W-1:0]    regWrData,
    input  wire logic                          regWr,
    input  wire logic                          regRd,
    output logic      [psq_pkg::DATA_W-1:0]    regRdData,
    // Host pins.
    input  wire logic                          wlanResetN,
    input  wire logic                          extSwitcherReq,
    input  wire logic                          extLowRippleReq,
    // Core clock requests, same clock domain.
    input  wire logic [CN-1:0]                 coreClkReq,
    // Resource and regulator controls.
    output logic      [N-1:0]                  resEnable,
    output logic                               coreSwitcherOn,
    output logic                               coreSwitcherPwm,
    output logic                               coreSwitcherLpBurst,
    output logic                               coreLinearOn,
    output logic                               lowNoiseLinearOn,
    output logic                               ioShutdown
);
    import psq_pkg::*;

    // ==========================================================
    // Pin synchronisers.
    logic [2:0] pinMeta_reg;
    logic [2:0] pinSync_reg;

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            pinMeta_reg <= 3'h0;
            pinSync_reg <= 3'h0;
        end else begin
            pinMeta_reg <= {extLowRippleReq, extSwitcherReq, wlanResetN};
            pinSync_reg <= pinMeta_reg;
        end
    end

    logic wlanRun;
    logic extSw;
    logic extLr;
    logic coreRst;

    assign wlanRun = pinSync_reg[0];
    assign extSw   = pinSync_reg[1];
    assign extLr   = pinSync_reg[2];
    // Holding the registers, request timer and resource states in reset while the WLAN is in reset discards their state.
    assign coreRst = reset | ~wlanRun;

    // ==========================================================
    // Sleep clock tick divider.
    localparam int DW = $clog2(DIV);
    logic [DW-1:0] divCnt_reg;
    logic          sleepTick_reg;

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            divCnt_reg    <= '0;
            sleepTick_reg <= 1'b0;
        end else if (divCnt_reg == DW'(DIV - 1)) begin
            divCnt_reg    <= '0;
            sleepTick_reg <= 1'b1;
        end else begin
            divCnt_reg    <= divCnt_reg + 1'b1;
            sleepTick_reg <= 1'b0;
        end
    end

    // ==========================================================
    // Configuration registers.
    logic [2:0]          ctrl_reg;
    logic [N-1:0]        minRes_reg;
    logic [TW-1:0]       reqCnt_reg;
    logic [N-1:0]        reqMask_reg;
    logic [$clog2(N)-1:0] dlySel_reg;
    logic [TW-1:0]       onDelay_reg  [N];
    logic [TW-1:0]       offDelay_reg [N];

    logic wrCtrl;
    logic wrMinRes;
    logic wrReqMask;
    logic wrDlySel;
    logic wrOnDly;
    logic wrOffDly;
    logic wrReqCnt;

    assign wrCtrl    = regWr && (regAddr == OFS_CTRL);
    assign wrMinRes  = regWr && (regAddr == OFS_MIN_RES);
    assign wrReqMask = regWr && (regAddr == OFS_REQ_MASK);
    assign wrDlySel  = regWr && (regAddr == OFS_DLY_SEL);
    assign wrOnDly   = regWr && (regAddr == OFS_ON_DLY);
    assign wrOffDly  = regWr && (regAddr == OFS_OFF_DLY);
    assign wrReqCnt  = regWr && (regAddr == OFS_REQ_CNT);

    // Writes while the WLAN is in reset are dropped; every register holds its reset value.
    always_ff @(posedge clk_sys) begin
        if (coreRst) begin
            ctrl_reg <= CTRL_RST;
        end else if (wrCtrl) begin
            ctrl_reg <= regWrData[2:0];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (coreRst) begin
            minRes_reg <= MIN_RES_RST;
        end else if (wrMinRes) begin
            minRes_reg <= regWrData[N-1:0];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (coreRst) begin
            reqMask_reg <= '0;
        end else if (wrReqMask) begin
            reqMask_reg <= regWrData[N-1:0];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (coreRst) begin
            dlySel_reg <= '0;
        end else if (wrDlySel) begin
            dlySel_reg <= regWrData[$clog2(N)-1:0];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (coreRst) begin
            for (int i = 0; i < N; i++) begin
                onDelay_reg[i] <= DELAY_RST;
            end
        end else if (wrOnDly) begin
            onDelay_reg[dlySel_reg] <= regWrData[TW-1:0];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (coreRst) begin
            for (int i = 0; i < N; i++) begin
                offDelay_reg[i] <= DELAY_RST;
            end
        end else if (wrOffDly) begin
            offDelay_reg[dlySel_reg] <= regWrData[TW-1:0];
        end
    end

    // The request timer counts sleep ticks; its resources stay requested while nonzero.
    always_ff @(posedge clk_sys) begin
        if (coreRst) begin
            reqCnt_reg <= '0;
        end else if (wrReqCnt) begin
            reqCnt_reg <= regWrData[TW-1:0];
        end else if (sleepTick_reg && reqCnt_reg != '0) begin
            reqCnt_reg <= reqCnt_reg - 1'b1;
        end
    end

    // ==========================================================
    // Required set.
    function automatic logic [N-1:0] closeDeps(input logic [N-1:0] req);
        logic [N-1:0] acc;
        acc = req;
        for (int pass = 0; pass < N; pass++) begin
            for (int i = 0; i < N; i++) begin
                if (acc[i]) begin
                    acc = acc | DEP_TABLE[i*N +: N];
                end
            end
        end
        return acc;
    endfunction

    logic [N-1:0] clkRes;
    logic [N-1:0] required;

    always_comb begin
        clkRes = '0;
        for (int c = 0; c < CN; c++) begin
            if (coreClkReq[c]) begin
                clkRes = clkRes | CLK_MAP[c*N +: N];
            end
        end
    end

    // Dependencies are folded in before any resource is examined.
    assign required = closeDeps(clkRes | minRes_reg | ((reqCnt_reg != '0) ? reqMask_reg : '0));

    // ==========================================================
    // Resource state and timers.
    psq_res_e     resState_reg [N];
    psq_res_e     stateMid     [N];
    psq_res_e     stateNext    [N];
    logic [TW-1:0] timer_reg   [N];
    logic [TW-1:0] timerMid    [N];
    logic [TW-1:0] timerNext   [N];
    logic [N-1:0] upMid;
    logic [N-1:0] onMid;

    always_comb begin
        for (int i = 0; i < N; i++) begin
            stateMid[i]  = resState_reg[i];
            timerMid[i]  = timer_reg[i];
            if (sleepTick_reg && timer_reg[i] != '0) begin
                timerMid[i] = timer_reg[i] - 1'b1;
                if (timer_reg[i] == TW'(1)) begin
                    stateMid[i] = (resState_reg[i] == RES_TURN_ON) ? RES_ENABLED : RES_DISABLED;
                end
            end
        end
        for (int i = 0; i < N; i++) begin
            upMid[i] = (stateMid[i] != RES_DISABLED);
            onMid[i] = (stateMid[i] == RES_ENABLED);
        end
    end

    always_comb begin
        logic depUp;
        depUp = 1'b0;
        for (int i = 0; i < N; i++) begin
            stateNext[i] = stateMid[i];
            timerNext[i] = timerMid[i];
            depUp = 1'b0;
            for (int j = 0; j < N; j++) begin
                if (DEP_TABLE[j*N + i] && upMid[j]) begin
                    depUp = 1'b1;
                end
            end
            if (sleepTick_reg) begin
                unique case (stateMid[i])
                    RES_ENABLED: begin
                        if (!required[i] && !depUp) begin
                            timerNext[i] = offDelay_reg[i];
                            stateNext[i] = (offDelay_reg[i] == '0) ? RES_DISABLED : RES_TURN_OFF;
                        end
                    end
                    RES_DISABLED: begin
                        if (required[i] && ((DEP_TABLE[i*N +: N] & ~onMid) == '0)) begin
                            timerNext[i] = onDelay_reg[i];
                            stateNext[i] = (onDelay_reg[i] == '0) ? RES_ENABLED : RES_TURN_ON;
                        end
                    end
                    RES_TURN_ON, RES_TURN_OFF: ;
                    default: begin
                        stateNext[i] = RES_DISABLED;
                        timerNext[i] = '0;
                    end
                endcase
            end
        end
    end

    // Timers hold zero in settled states and count while a state is in transition.
    always_ff @(posedge clk_sys) begin
        if (coreRst) begin
            for (int i = 0; i < N; i++) begin
                resState_reg[i] <= RES_DISABLED;
                timer_reg[i]    <= '0;
            end
        end else begin
            for (int i = 0; i < N; i++) begin
                resState_reg[i] <= stateNext[i];
                timer_reg[i]    <= timerNext[i];
            end
        end
    end

    logic [N-1:0] onFlag;
    logic [N-1:0] pendFlag;

    always_comb begin
        for (int i = 0; i < N; i++) begin
            onFlag[i]   = (resState_reg[i] == RES_ENABLED) || (resState_reg[i] == RES_TURN_OFF);
            pendFlag[i] = (resState_reg[i] == RES_TURN_ON) || (resState_reg[i] == RES_TURN_OFF);
        end
    end

    // ==========================================================
    // Resource enables.
    // A resource held in WLAN reset stays unpowered even if a tick would start it.
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            resEnable <= '0;
        end else begin
            for (int i = 0; i < N; i++) begin
                resEnable[i] <= !coreRst && ((stateNext[i] == RES_ENABLED) || (stateNext[i] == RES_TURN_ON));
            end
        end
    end

    // ==========================================================
    // Regulator control.
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            coreSwitcherOn      <= 1'b0;
            coreSwitcherPwm     <= 1'b0;
            coreSwitcherLpBurst <= 1'b0;
        end else begin
            coreSwitcherOn <= wlanRun | extSw;
            if (!wlanRun) begin
                coreSwitcherPwm <= extSw & extLr;
            end else begin
                coreSwitcherPwm <= ctrl_reg[CTRL_PWM_BIT] | (extSw & extLr);
            end
            // Host load steps right after the low-ripple request are the host's concern.
            coreSwitcherLpBurst <= wlanRun & ~extSw & ~ctrl_reg[CTRL_PWM_BIT]
                                   & ctrl_reg[CTRL_LPBURST_BIT];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            coreLinearOn     <= 1'b0;
            lowNoiseLinearOn <= 1'b0;
        end else begin
            coreLinearOn     <= wlanRun;
            lowNoiseLinearOn <= wlanRun & ctrl_reg[CTRL_LNLIN_BIT];
        end
    end

    // Shutdown only when neither the WLAN nor the external switcher request needs the device.
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            ioShutdown <= 1'b1;
        end else begin
            ioShutdown <= ~wlanRun & ~extSw;
        end
    end

    // ==========================================================
    // Register reads.
    always_ff @(posedge clk_sys) begin
        if (reset || !regRd) begin
            regRdData <= '0;
        end else begin
            unique case (regAddr)
                OFS_CTRL:     regRdData <= DATA_W'(ctrl_reg);
                OFS_MIN_RES:  regRdData <= DATA_W'(minRes_reg);
                OFS_RES_ON:   regRdData <= DATA_W'(onFlag);
                OFS_RES_PEND: regRdData <= DATA_W'(pendFlag);
                OFS_REQ_CNT:  regRdData <= DATA_W'(reqCnt_reg);
                OFS_REQ_MASK: regRdData <= DATA_W'(reqMask_reg);
                OFS_REQUIRED: regRdData <= DATA_W'(required);
                OFS_REG_STAT: regRdData <= DATA_W'({coreSwitcherLpBurst, coreLinearOn,
                                                    coreSwitcherPwm, coreSwitcherOn});
                OFS_DLY_SEL:  regRdData <= DATA_W'(dlySel_reg);
                OFS_ON_DLY:   regRdData <= DATA_W'(onDelay_reg[dlySel_reg]);
                OFS_OFF_DLY:  regRdData <= DATA_W'(offDelay_reg[dlySel_reg]);
                default:      regRdData <= '0;
            endcase
        end
    end

endmodule

`default_nettype wire

// [verif/psq_sequencer_props.sv]
// Checker for the power resource sequencer, bound to its top module.
// Assumes the default dependency table, where resource i depends on i-1.
`timescale 1ns/100ps
`default_nettype none

module psq_sequencer_props #(
    parameter int N   = 8,
    parameter int DIV = 4
) (
    // Clock and reset.
    input wire logic                       clk_sys,
    input wire logic                       reset,
    // Register port.
    input wire logic                       regRd,
    input wire logic [psq_pkg::DATA_W-1:0] regRdData,
    // Host pins.
    input wire logic                       wlanResetN,
    input wire logic                       extSwitcherReq,
    input wire logic                       extLowRippleReq,
    // Outputs watched.
    input wire logic [N-1:0]               resEnable,
    input wire logic                       coreSwitcherOn,
    input wire logic                       coreSwitcherPwm,
    input wire logic                       coreSwitcherLpBurst,
    input wire logic                       coreLinearOn,
    input wire logic                       ioShutdown
);
    // ==========================================================
    // Helpers: pin history only counts once the synchronisers hold real samples.
    logic [2:0] sinceRst;
    logic [5:0] runHist;
    logic       settled;
    logic       runSteady;

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            sinceRst <= 3'h0;
        end else if (sinceRst != 3'h7) begin
            sinceRst <= sinceRst + 3'h1;
        end
    end

    always_ff @(posedge clk_sys) begin
        runHist <= {runHist[4:0], wlanResetN};
    end

    assign settled   = (sinceRst >= 3'h4);
    assign runSteady = settled && (&runHist);

    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);

    // ==========================================================
    // Assertions.
    a_switcher_on_pins: assert property (settled |-> coreSwitcherOn == ($past(wlanResetN, 3) | $past(extSwitcherReq, 3)))
        else $error("switcher on does not follow the pins");
    a_linear_on_pins: assert property (settled |-> coreLinearOn == $past(wlanResetN, 3))
        else $error("linear regulator does not follow reset pin");
    a_shutdown_pins: assert property (settled |-> ioShutdown == !($past(wlanResetN, 3) | $past(extSwitcherReq, 3)))
        else $error("shutdown does not follow the pins");
    a_pwm_forced: assert property (settled && $past(extSwitcherReq, 3) && $past(extLowRippleReq, 3) |-> coreSwitcherPwm)
        else $error("both requests high but not in pwm");
    a_reset_burst_mode: assert property (settled && !$past(wlanResetN, 3) |-> coreSwitcherPwm == ($past(extSwitcherReq, 3) & $past(extLowRippleReq, 3)))
        else $error("mode in reset does not follow low-ripple pin");
    a_lpburst_no_ext: assert property (settled && coreSwitcherLpBurst |-> $past(wlanResetN, 3) && !$past(extSwitcherReq, 3))
        else $error("low-power burst while serving external request");
    a_enable_dep_order: assert property (runSteady |-> ((resEnable & ~$past(resEnable)) & ~{$past(resEnable[N-2:0]), 1'b1}) == '0)
        else $error("resource powered before its dependency");
    a_disable_dep_order: assert property (runSteady |-> ((~resEnable & $past(resEnable)) & {1'b0, $past(resEnable[N-1:1])}) == '0)
        else $error("resource dropped while a dependent was powered");
    a_tick_spacing: assert property (runSteady && $changed(resEnable) |=> ($stable(resEnable) || !runSteady) [*3])
        else $error("resource outputs moved between sleep ticks");
    a_read_idle_zero: assert property (!regRd |=> regRdData == '0)
        else $error("read data not zero outside read answer");
endmodule

bind psq_sequencer psq_sequencer_props #(.N(N), .DIV(DIV)) chk_u (
    .clk_sys(clk_sys), .reset(reset), .regRd(regRd), .regRdData(regRdData),
    .wlanResetN(wlanResetN), .extSwitcherReq(extSwitcherReq), .extLowRippleReq(extLowRippleReq),
    .resEnable(resEnable), .coreSwitcherOn(coreSwitcherOn), .coreSwitcherPwm(coreSwitcherPwm),
    .coreSwitcherLpBurst(coreSwitcherLpBurst), .coreLinearOn(coreLinearOn), .ioShutdown(ioShutdown)
);

`default_nettype wire

// [verif/psq_host_model.sv]
// Host model driving the reset and regulator request pins.
// Assumes the bench commands pin levels; pins change just after a clock edge.
`timescale 1ns/100ps
`default_nettype none

module psq_host_model (
    // Clock.
    input wire logic  clk_sys,
    // Commands from the bench.
    input wire logic  runCmd,
    input wire logic  extCmd,
    input wire logic  rippleCmd,
    // Pins toward the device.
    output var logic  wlanResetN,
    output var logic  extSwitcherReq,
    output var logic  extLowRippleReq
);
    initial begin
        wlanResetN      = 1'b0;
        extSwitcherReq  = 1'b0;
        extLowRippleReq = 1'b0;
    end

    // The host never raises regulator load here, so no settling wait is owed.
    always @(posedge clk_sys) begin
        wlanResetN      <= runCmd;
        extSwitcherReq  <= extCmd;
        extLowRippleReq <= rippleCmd;
    end
endmodule

`default_nettype wire

// [verif/tb.sv]
// Self-checking bench for the power resource sequencer.
// Assumes the default dependency table and clock map, with a short sleep divider.
`timescale 1ns/100ps
`default_nettype none

module tb;
    import psq_pkg::*;
    localparam int DIVS = 4;
    logic        clk_sys = 1'b0;
    logic        reset = 1'b1;
    logic [7:0]  regAddr = 8'h00;
    logic [31:0] regWrData = 32'h0;
    logic        regWr = 1'b0;
    logic        regRd = 1'b0;
    logic [31:0] regRdData;
    logic [3:0]  coreClkReq = 4'h0;
    logic        runCmd = 1'b0;
    logic        extCmd = 1'b0;
    logic        rippleCmd = 1'b0;
    logic        wlanResetN, extSwitcherReq, extLowRippleReq;
    logic [7:0]  resEnable;
    logic        swOn, swPwm, swLpb, linOn, lnlOn, ioShutdown;
    logic [31:0] seed = 32'h0000000b;
    logic [31:0] d, r;
    logic [5:0]  e;
    logic [2:0]  ctrl;
    int          fails = 0;
    int          compares = 0;
    int          cycles = 0;

    always #5 clk_sys = ~clk_sys;

    psq_host_model host_u (.clk_sys(clk_sys), .runCmd(runCmd), .extCmd(extCmd), .rippleCmd(rippleCmd),
        .wlanResetN(wlanResetN), .extSwitcherReq(extSwitcherReq), .extLowRippleReq(extLowRippleReq));

    psq_sequencer #(.DIV(DIVS)) dut_u (.clk_sys(clk_sys), .reset(reset), .regAddr(regAddr),
        .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
        .wlanResetN(wlanResetN), .extSwitcherReq(extSwitcherReq), .extLowRippleReq(extLowRippleReq),
        .coreClkReq(coreClkReq), .resEnable(resEnable), .coreSwitcherOn(swOn), .coreSwitcherPwm(swPwm),
        .coreSwitcherLpBurst(swLpb), .coreLinearOn(linOn), .lowNoiseLinearOn(lnlOn), .ioShutdown(ioShutdown));

    // ==========================================================
    // Helpers.
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    function automatic logic [7:0] closure(input logic [7:0] m);
        for (int i = 7; i > 0; i--) if (m[i]) m[i-1] = 1'b1;
        return m;
    endfunction

    // Returns {lowNoise, shutdown, linear, lpBurst, pwm, on}.
    function automatic logic [5:0] regExp(input logic run, ext, lr, input logic [2:0] c);
        return {run & c[2], !run & !ext, run, run & !ext & !c[0] & c[1], run ? (c[0] | (ext & lr)) : (ext & lr), run | ext};
    endfunction

    task automatic check(input string name, input logic [31:0] exp, got);
        compares++;
        if (got !== exp) begin
            $display("[ERR] %s expected %h seen %h", name, exp, got);
            fails++;
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk_sys);
        regWr <= 1'b1;
        regAddr <= a;
        regWrData <= v;
        @(posedge clk_sys);
        regWr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge clk_sys);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge clk_sys);
        regRd <= 1'b0;
        #1 v = regRdData;
    endtask

    task automatic waitEn(input logic [7:0] exp);
        for (int i = 0; i < 800 && resEnable !== exp; i++) @(posedge clk_sys);
        check("resEnable", {24'h0, exp}, {24'h0, resEnable});
    endtask

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", compares, fails);
        if (fails == 0 && compares > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 12000) begin
            fails++;
            test_done();
        end
    end

    // ==========================================================
    // Main sequence.
    initial begin
        repeat (6) @(posedge clk_sys);
        reset <= 1'b0;
        repeat (5) @(posedge clk_sys);
        check("shutdown", 32'h1, {31'h0, ioShutdown});
        wr(OFS_MIN_RES, 32'h000000ff);
        rd(OFS_MIN_RES, d);
        check("minResInReset", 32'h1, d);
        for (int k = 0; k < 24; k++) begin
            r = rnd();
            if (k >= 8) r[2:0] = r[8:6];
            else r[2:0] = k[2:0];
            runCmd <= r[2];
            extCmd <= r[1];
            rippleCmd <= r[0];
            repeat (6) @(posedge clk_sys);
            ctrl = r[2] ? r[5:3] : 3'h0;
            wr(OFS_CTRL, {29'h0, r[5:3]});
            repeat (2) @(posedge clk_sys);
            e = regExp(r[2], r[1], r[0], ctrl);
            check("regulators", {26'h0, e}, {26'h0, lnlOn, ioShutdown, linOn, swLpb, swPwm, swOn});
            rd(OFS_REG_STAT, d);
            check("regStat", {28'h0, e[2], e[3], e[1], e[0]}, d);
        end
        runCmd <= 1'b0;
        extCmd <= 1'b0;
        repeat (6) @(posedge clk_sys);
        runCmd <= 1'b1;
        waitEn(8'h01);
        rd(OFS_RES_PEND, d);
        check("pendOn", 32'h1, d);
        repeat (12) @(posedge clk_sys);
        rd(OFS_RES_ON, d);
        check("onAfterDelay", 32'h1, d);
        rd(OFS_RES_PEND, d);
        check("pendCleared", 32'h0, d);
        for (int i = 0; i < 8; i++) begin
            r = rnd();
            wr(OFS_DLY_SEL, i);
            wr(OFS_ON_DLY, i[0] ? 32'h0 : {30'h0, r[1:0]} + 32'h1);
            wr(OFS_OFF_DLY, {31'h0, r[2]});
        end
        rd(OFS_OFF_DLY, d);
        check("offDelay", {31'h0, r[2]}, d);
        wr(OFS_MIN_RES, 32'h80);
        rd(OFS_REQUIRED, d);
        check("required", {24'h0, closure(8'h80)}, d);
        waitEn(8'hff);
        coreClkReq <= 4'h2;
        wr(OFS_MIN_RES, 32'h01);
        rd(OFS_REQUIRED, d);
        check("requiredClk", {24'h0, closure(8'h21)}, d);
        waitEn(8'h3f);
        wr(OFS_REQ_MASK, 32'h80);
        wr(OFS_REQ_CNT, 32'h3);
        rd(OFS_REQUIRED, d);
        check("requiredTimer", {24'h0, closure(8'ha1)}, d);
        repeat (40) @(posedge clk_sys);
        rd(OFS_REQ_CNT, d);
        check("reqCntDone", 32'h0, d);
        waitEn(8'h3f);
        rd(8'h3c, d);
        check("unmapped", 32'h0, d);
        wr(OFS_MIN_RES, 32'h03);
        runCmd <= 1'b0;
        repeat (8) @(posedge clk_sys);
        check("offInReset", 32'h1, {23'h0, resEnable, ioShutdown});
        runCmd <= 1'b1;
        repeat (6) @(posedge clk_sys);
        rd(OFS_MIN_RES, d);
        check("minResFresh", 32'h1, d);
        test_done();
    end
endmodule

`default_nettype wire
